// *** src/coef_if.sv ***
// Interface: coefficient store port between control and memory
`timescale 1ns/100ps
interface coef_if;
  logic       we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface // coef_if

// *** src/coef_store.sv ***
// Memory of result and coefficient bytes with registered read
`timescale 1ns/100ps
module coef_store
  import conv_ctrl_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  coef_if.mem       port
);
  logic [7:0] mem_r [16];
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= 8'h00_00;
      end
      mem_r[5]  <= POFS_RST[23:16];
      mem_r[9]  <= AOFS_RST[15:8];
      rdata_r   <= 8'h00_00;
    end else if (ce_i) begin
      if (port.we) begin
        mem_r[port.waddr] <= port.wdata;
      end
      rdata_r <= mem_r[port.raddr];
    end
  end

  assign port.rdata = rdata_r;
endmodule // coef_store

// *** src/conv_ctrl.sv ***
// Control of the primary and auxiliary sigma-delta converters
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module conv_ctrl
  import conv_ctrl_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic        noref_pin_i,
  input  wire logic [23:0] p_sample_i,
  input  wire logic        p_clamp_i,
  input  wire logic [15:0] a_sample_i,
  input  wire logic        a_clamp_i,
  output logic             p_rst_o,
  output logic             a_rst_o,
  output logic             p_ext_ref_o,
  output logic             a_ext_ref_o,
  output logic [1:0]       p_pair_o,
  output logic [1:0]       a_input_o,
  output logic [2:0]       p_range_o,
  output logic             p_zero_short_o,
  output logic             fs_ref_o,
  output logic [7:0]       eff_ratio_o
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_r, pcfg_r, acfg_r, decim_r;
  logic prdy_r, ardy_r, cal_r, perr_r, aerr_r;
  logic noref_m_r, noref_r, rd_pend_r;
  logic [PERIOD_W-1:0] tick_r;
  logic [1:0] pcnt_r, acnt_r;
  logic        a_pend_r;
  logic [15:0] a_val_r;
  logic [3:0]  a_dst_r;
  seq_state_t state_r, state_nxt;
  coef_if cif ();

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire wr_mode  = ce_i && sfr_wr_i && sfr_addr_i == MODE_ADDR;
  wire wr_pcfg  = ce_i && sfr_wr_i && sfr_addr_i == PCFG_ADDR;
  wire wr_acfg  = ce_i && sfr_wr_i && sfr_addr_i == ACFG_ADDR;
  wire wr_decim = ce_i && sfr_wr_i && sfr_addr_i == DECIM_ADDR;
  wire wr_stat  = ce_i && sfr_wr_i && sfr_addr_i == STATUS_ADDR;
  wire [2:0] md      = mode_r[MODE_LSB +: MODE_W];
  wire       p_en    = mode_r[MODE_PEN_BIT];
  wire       a_en    = mode_r[MODE_AEN_BIT];
  wire [7:0] mode_w  = sfr_wdata_i & MODE_MASK;
  wire       p_en_w  = mode_w[MODE_PEN_BIT];
  wire       a_en_w  = mode_w[MODE_AEN_BIT];
  wire       active  = (p_en || a_en) && md != MD_PDOWN;
  wire       is_cal  = md[2];
  wire       a_temp  = acfg_r[INSEL_LSB +: 2] == AIN_TEMP;
  wire       a_bip   = !acfg_r[UNI_BIT];
  // Both-converter reset sources
  wire rst_both = wr_mode || (wr_pcfg && p_en) ||
                  (wr_mode && p_en_w && !p_en);
  // Aux-only reset sources
  wire rst_aux  = wr_acfg || (wr_mode && a_en_w && !a_en);

  // Coefficient store address map
  function automatic logic [3:0] coef_idx(input logic [7:0] a);
    unique case (a)
      PRES_L_ADDR: coef_idx = 4'h0;
      PRES_M_ADDR: coef_idx = 4'h1;
      PRES_H_ADDR: coef_idx = 4'h2;
      ARES_L_ADDR: coef_idx = 4'h6;
      ARES_H_ADDR: coef_idx = 4'h7;
      POFS_L_ADDR: coef_idx = 4'h3;
      POFS_M_ADDR: coef_idx = 4'h4;
      POFS_H_ADDR: coef_idx = 4'h5;
      AOFS_L_ADDR: coef_idx = 4'h8;
      AOFS_H_ADDR: coef_idx = 4'h9;
      PGN_L_ADDR:  coef_idx = 4'hA;
      PGN_M_ADDR:  coef_idx = 4'hB;
      PGN_H_ADDR:  coef_idx = 4'hC;
      AGN_L_ADDR:  coef_idx = 4'hD;
      AGN_H_ADDR:  coef_idx = 4'hE;
      default:     coef_idx = 4'hF;
    endcase
  endfunction

  wire [3:0] sfr_idx   = coef_idx(sfr_addr_i);
  wire       sfr_coef  = sfr_idx >= 4'h3 && sfr_idx <= 4'hE &&
                         sfr_idx != 4'h6 && sfr_idx != 4'h7;
  wire       sw_coef_we = ce_i && sfr_wr_i && sfr_coef &&
                          md == MD_PDOWN;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Calibration forces the longest output period
  assign eff_ratio_o = is_cal ? DECIM_MAX : decim_r;
  wire [PERIOD_W-1:0] plen = period_len(eff_ratio_o);
  wire out_tick = state_r != SEQ_OFF && state_r != SEQ_HOLD &&
                  tick_r == plen - PERIOD_W'(1);
  wire p_done = out_tick && p_en && pcnt_r == 2'(FIRST_PERIODS - 1);
  wire a_done = out_tick && a_en && acnt_r == 2'(FIRST_PERIODS - 1);
  wire any_done = p_done || a_done;
  wire all_done = (!p_en || p_done || pcnt_r == 2'(FIRST_PERIODS)) &&
                  (!a_en || a_done || acnt_r == 2'(FIRST_PERIODS));
  // Continuous mode rearms one period short of a result
  wire p_rearm = md == MD_CONT && pcnt_r == 2'(FIRST_PERIODS);
  wire a_rearm = md == MD_CONT && acnt_r == 2'(FIRST_PERIODS);
  wire p_step  = out_tick && pcnt_r != 2'(FIRST_PERIODS);
  wire a_step  = out_tick && acnt_r != 2'(FIRST_PERIODS);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SEQ_OFF, SEQ_HOLD, SEQ_CONV, SEQ_CAL: begin
        if (!(p_en || a_en) || md == MD_PDOWN) state_nxt = SEQ_OFF;
        else if (md == MD_IDLE) state_nxt = SEQ_HOLD;
        else if (is_cal) state_nxt = SEQ_CAL;
        else state_nxt = SEQ_CONV;
      end
    endcase
  end

  // Single and calibration cycles end in power-down
  wire finish = (md == MD_SINGLE || is_cal) && out_tick &&
                all_done && state_r != SEQ_OFF;
  wire cal_fail_a = is_cal && a_done && a_temp;

  // ----------------------------------------------------------------
  // Result and coefficient writes
  // ----------------------------------------------------------------
  logic [3:0] hw_idx;
  logic [7:0] hw_data;
  logic       hw_we;
  logic [2:0] wr_seq_r;
  logic       wr_is_a_r;
  logic [23:0] wr_val_r;
  logic [3:0]  wr_base_r;

  assign hw_we   = wr_seq_r != 3'h0;
  assign hw_idx  = wr_base_r + 4'(wr_seq_r - 3'h1);
  assign hw_data = wr_val_r[8*(wr_seq_r - 3'h1) +: 8];

  // Bytes of one result go into the store one per cycle
  assign cif.we    = hw_we || sw_coef_we;
  assign cif.waddr = hw_we ? hw_idx : sfr_idx;
  assign cif.wdata = hw_we ? hw_data : sfr_wdata_i;
  assign cif.raddr = sfr_idx;

  coef_store u_store (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .port   (cif.mem)
  );

  function automatic logic p_straight_binary();
    return pcfg_r[UNI_BIT];
  endfunction

  // Samples are offset binary; unipolar moves zero to all zeros
  wire [23:0] p_code = p_sample_i ^ PBIP_ZERO ^
                       (p_straight_binary() ? PUNI_ZERO : PBIP_ZERO);
  wire [15:0] a_code = a_sample_i ^ ABIP_ZERO ^
                       (acfg_r[UNI_BIT] ? AUNI_ZERO : ABIP_ZERO);

  wire p_take = p_done && !prdy_r;
  wire a_take = a_done && !ardy_r && !cal_fail_a;
  wire [3:0] p_base = !is_cal ? 4'h0 : (md[0] ? 4'hA : 4'h3);
  wire [3:0] a_base = !is_cal ? 4'h6 : (md[0] ? 4'hD : 4'h8);
  // Held aux result goes out once the byte queue is free
  wire a_start = wr_seq_r == 3'h0 && !p_take && a_pend_r;

  // ----------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_r <= MODE_RST;
      pcfg_r <= PCFG_RST;
      acfg_r <= ACFG_RST;
      decim_r <= DECIM_RST;
      {prdy_r, ardy_r, cal_r, perr_r, aerr_r} <= 5'h00;
      {noref_m_r, noref_r, rd_pend_r} <= 3'h0;
      state_r <= SEQ_OFF;
      tick_r <= '0;
      {pcnt_r, acnt_r} <= 4'h0;
      wr_seq_r <= 3'h0;
      wr_is_a_r <= 1'b0;
      wr_val_r <= 24'h00_0000;
      wr_base_r <= 4'h0;
      a_pend_r <= 1'b0;
      a_val_r <= 16'h0000;
      a_dst_r <= 4'h0;
    end else if (ce_i) begin
      noref_m_r <= noref_pin_i;
      noref_r   <= noref_m_r;
      rd_pend_r <= sfr_rd_i;
      state_r   <= state_nxt;
      if (wr_mode) mode_r <= mode_w;
      else if (finish) mode_r[MODE_LSB +: MODE_W] <= MD_PDOWN;
      if (wr_pcfg) pcfg_r <= sfr_wdata_i & PCFG_MASK;
      if (wr_acfg) acfg_r <= sfr_wdata_i & ACFG_MASK;
      if (wr_decim && !active) decim_r <= sfr_wdata_i;
      // Output period counter restarts on both-converter reset
      if (rst_both || state_r == SEQ_OFF || state_r == SEQ_HOLD ||
          out_tick) tick_r <= '0;
      else tick_r <= tick_r + PERIOD_W'(1);
      if (rst_both || !p_en) pcnt_r <= 2'h0;
      else if (p_rearm) pcnt_r <= 2'(FIRST_PERIODS - 1);
      else if (p_step) pcnt_r <= pcnt_r + 2'h1;
      if (rst_both || rst_aux || !a_en) acnt_r <= 2'h0;
      else if (a_rearm) acnt_r <= 2'(FIRST_PERIODS - 1);
      else if (a_step) acnt_r <= acnt_r + 2'h1;
      // Status flags: hardware set wins over software clear
      if (p_done) prdy_r <= 1'b1;
      else if ((wr_mode && mode_w[MODE_LSB +: MODE_W] != MD_PDOWN) ||
               (wr_stat && !sfr_wdata_i[STAT_PRDY_BIT])) prdy_r <= 1'b0;
      if (a_done) ardy_r <= 1'b1;
      else if ((wr_mode && mode_w[MODE_LSB +: MODE_W] != MD_PDOWN) ||
               (wr_stat && !sfr_wdata_i[STAT_ARDY_BIT])) ardy_r <= 1'b0;
      if (finish && is_cal) cal_r <= 1'b1;
      else if (wr_mode && mode_w[MODE_LSB +: MODE_W] > MD_IDLE) cal_r <= 1'b0;
      if (p_take && p_clamp_i) perr_r <= 1'b1;
      else if (wr_mode) perr_r <= 1'b0;
      if ((a_take && a_clamp_i) || cal_fail_a) aerr_r <= 1'b1;
      else if (wr_mode) aerr_r <= 1'b0;
      // Aux result captured now, written after primary bytes
      if (a_take) begin
        a_pend_r <= 1'b1;
        a_val_r  <= a_code;
        a_dst_r  <= a_base;
      end else if (a_start) begin
        a_pend_r <= 1'b0;
      end
      // Queue result bytes, primary before auxiliary
      if (wr_seq_r != 3'h0) begin
        wr_seq_r <= (wr_seq_r == (wr_is_a_r ? 3'h2 : 3'h3)) ? 3'h0
                    : wr_seq_r + 3'h1;
      end else if (p_take) begin
        wr_seq_r <= 3'h1; wr_is_a_r <= 1'b0;
        wr_val_r <= p_code; wr_base_r <= p_base;
      end else if (a_start) begin
        wr_seq_r  <= 3'h1;
        wr_is_a_r <= 1'b1;
        wr_val_r  <= {8'h00_00, a_val_r};
        wr_base_r <= a_dst_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and converter controls
  // ----------------------------------------------------------------
  wire [7:0] stat_rd = {prdy_r, ardy_r, cal_r, noref_r && active,
                        perr_r, aerr_r, 2'b00} & STAT_MASK;
  always_comb begin
    unique case (sfr_addr_i)
      MODE_ADDR:   sfr_rdata_o = mode_r;
      PCFG_ADDR:   sfr_rdata_o = pcfg_r;
      ACFG_ADDR:   sfr_rdata_o = acfg_r;
      DECIM_ADDR:  sfr_rdata_o = decim_r;
      STATUS_ADDR: sfr_rdata_o = stat_rd;
      default:     sfr_rdata_o = (sfr_idx != 4'hF && rd_pend_r) ? cif.rdata
                                                               : 8'h00_00;
    endcase
  end

  assign p_rst_o   = rst_both || !p_en || state_r != SEQ_CONV &&
                     state_r != SEQ_CAL;
  assign a_rst_o   = rst_both || rst_aux || !a_en ||
                     (state_r != SEQ_CONV && state_r != SEQ_CAL);
  assign p_ext_ref_o = pcfg_r[EXTREF_BIT];
  assign a_ext_ref_o = acfg_r[EXTREF_BIT];
  assign p_pair_o    = pcfg_r[INSEL_LSB +: 2];
  assign a_input_o   = acfg_r[INSEL_LSB +: 2];
  assign p_range_o   = pcfg_r[RANGE_LSB +: 3];
  assign p_zero_short_o = md == MD_IZS;
  assign fs_ref_o    = md == MD_IFS;
endmodule // conv_ctrl

// *** src/conv_ctrl_pkg.sv ***
// Package: register offsets, fields, reset values and timing for converter control
package conv_ctrl_pkg;
  // Special function register addresses
  localparam logic [7:0] STATUS_ADDR  = 8'h00_D8;
  localparam logic [7:0] MODE_ADDR    = 8'h00_D1;
  localparam logic [7:0] PCFG_ADDR    = 8'h00_D2;
  localparam logic [7:0] ACFG_ADDR    = 8'h00_D3;
  localparam logic [7:0] DECIM_ADDR   = 8'h00_D4;
  localparam logic [7:0] PRES_L_ADDR  = 8'h00_D9;
  localparam logic [7:0] PRES_M_ADDR  = 8'h00_DA;
  localparam logic [7:0] PRES_H_ADDR  = 8'h00_DB;
  localparam logic [7:0] ARES_L_ADDR  = 8'h00_DC;
  localparam logic [7:0] ARES_H_ADDR  = 8'h00_DD;
  localparam logic [7:0] POFS_L_ADDR  = 8'h00_E1;
  localparam logic [7:0] POFS_M_ADDR  = 8'h00_E2;
  localparam logic [7:0] POFS_H_ADDR  = 8'h00_E3;
  localparam logic [7:0] AOFS_L_ADDR  = 8'h00_E4;
  localparam logic [7:0] AOFS_H_ADDR  = 8'h00_E5;
  localparam logic [7:0] PGN_L_ADDR   = 8'h00_E9;
  localparam logic [7:0] PGN_M_ADDR   = 8'h00_EA;
  localparam logic [7:0] PGN_H_ADDR   = 8'h00_EB;
  localparam logic [7:0] AGN_L_ADDR   = 8'h00_EC;
  localparam logic [7:0] AGN_H_ADDR   = 8'h00_ED;

  // Reset values, maximum ratio and code zero points
  localparam logic [7:0] PCFG_RST   = 8'h00_07;
  localparam logic [7:0] ACFG_RST   = 8'h00_00;
  localparam logic [7:0] MODE_RST   = 8'h00_00;
  localparam logic [7:0] DECIM_RST  = 8'h00_45;
  localparam logic [7:0] DECIM_MAX  = 8'h00_FF;
  localparam logic [23:0] POFS_RST  = 24'h80_0000;
  localparam logic [15:0] AOFS_RST  = 16'h8000;
  localparam logic [23:0] PBIP_ZERO = 24'h80_0000;
  localparam logic [23:0] PUNI_ZERO = 24'h00_0000;
  localparam logic [15:0] ABIP_ZERO = 16'h8000;
  localparam logic [15:0] AUNI_ZERO = 16'h0000;

  // Field masks: writable config bits and readable status bits, other bits read zero
  localparam logic [7:0] MODE_MASK = 8'h00_37;
  localparam logic [7:0] PCFG_MASK = 8'h00_7F;
  localparam logic [7:0] ACFG_MASK = 8'h00_78;
  localparam logic [7:0] STAT_MASK = 8'h00_EC;

  // Field positions
  localparam int MODE_PEN_BIT  = 5;
  localparam int MODE_AEN_BIT  = 4;
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 3;
  localparam int EXTREF_BIT    = 6;
  localparam int INSEL_LSB     = 4;
  localparam int UNI_BIT       = 3;
  localparam int RANGE_LSB     = 0;
  localparam int STAT_PRDY_BIT = 7;
  localparam int STAT_ARDY_BIT = 6;
  localparam int STAT_CAL_BIT  = 5;
  localparam int STAT_NOREF_BIT= 4;
  localparam int STAT_PERR_BIT = 3;
  localparam int STAT_AERR_BIT = 2;

  // Conversion mode and aux input encodings
  localparam logic [2:0] MD_PDOWN  = 3'h0;
  localparam logic [2:0] MD_IDLE   = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_CONT   = 3'h3;
  localparam logic [2:0] MD_IZS    = 3'h4;
  localparam logic [2:0] MD_IFS    = 3'h5;
  localparam logic [2:0] MD_SZS    = 3'h6;
  localparam logic [2:0] MD_SFS    = 3'h7;
  localparam logic [1:0] AIN_TEMP  = 2'h2;

  // Output period is 3 * 8 * ratio modulator clocks
  localparam int unsigned PERIOD_MUL = 24;
  localparam int unsigned FIRST_PERIODS = 2;
  localparam int unsigned AUX_ALIGN_MAX = 3;
  localparam int PERIOD_W = 13;

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_HOLD,
    SEQ_CONV,
    SEQ_CAL
  } seq_state_t;

  function automatic logic [PERIOD_W-1:0] period_len(input logic [7:0] r);
    return PERIOD_W'(r * PERIOD_MUL);
  endfunction
endpackage

// *** tb/conv_ctrl_assertions.sv ***
// Checker of field outputs, readback and reset pulses of converter control
`timescale 1ns/100ps
module conv_ctrl_assertions
  import conv_ctrl_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_rdata_o,
  input  wire logic       p_rst_o,
  input  wire logic       a_rst_o,
  input  wire logic       p_ext_ref_o,
  input  wire logic       a_ext_ref_o,
  input  wire logic [1:0] p_pair_o,
  input  wire logic [1:0] a_input_o,
  input  wire logic [2:0] p_range_o,
  input  wire logic       p_zero_short_o,
  input  wire logic       fs_ref_o,
  input  wire logic [7:0] eff_ratio_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  wire wr_mode = ce_i && sfr_wr_i && (sfr_addr_i == MODE_ADDR);
  wire wr_pcfg = ce_i && sfr_wr_i && (sfr_addr_i == PCFG_ADDR);
  wire wr_acfg = ce_i && sfr_wr_i && (sfr_addr_i == ACFG_ADDR);

  mode_reset_both_a: assert property (
    wr_mode |-> ##[0:1] (p_rst_o && a_rst_o))
    else $error("mode write did not reset both converters");
  aux_cfg_reset_a: assert property (
    wr_acfg |-> ##[0:1] a_rst_o)
    else $error("aux config write did not reset aux");
  pcfg_fields_a: assert property (
    wr_pcfg |=> p_ext_ref_o == $past(sfr_wdata_i[6]) &&
      p_pair_o == $past(sfr_wdata_i[5:4]) &&
      p_range_o == $past(sfr_wdata_i[2:0]))
    else $error("primary fields do not follow write");
  acfg_fields_a: assert property (
    wr_acfg |=> a_ext_ref_o == $past(sfr_wdata_i[6]) &&
      a_input_o == $past(sfr_wdata_i[5:4]))
    else $error("aux fields do not follow write");
  pcfg_read_a: assert property (
    sfr_addr_i == PCFG_ADDR |-> !sfr_rdata_o[7] &&
      sfr_rdata_o[6] == p_ext_ref_o && sfr_rdata_o[5:4] == p_pair_o &&
      sfr_rdata_o[2:0] == p_range_o)
    else $error("primary config readback wrong");
  acfg_read_a: assert property (
    sfr_addr_i == ACFG_ADDR |-> !sfr_rdata_o[7] &&
      sfr_rdata_o[6] == a_ext_ref_o && sfr_rdata_o[5:4] == a_input_o &&
      sfr_rdata_o[2:0] == 3'h0)
    else $error("aux config readback wrong");
  mode_rsvd_a: assert property (
    sfr_addr_i == MODE_ADDR |-> (sfr_rdata_o & 8'hc8) == 8'h00)
    else $error("mode reserved bits not zero");
  cal_ratio_max_a: assert property (
    (p_zero_short_o || fs_ref_o) |-> eff_ratio_o == 8'hff)
    else $error("calibration not at maximum ratio");
  cal_clears_rdy_a: assert property (
    (wr_mode && sfr_wdata_i[2]) |-> ##2
      (sfr_addr_i != STATUS_ADDR || sfr_rdata_o[7:5] == 3'h0))
    else $error("calibration start left flags set");
  cal_sel_excl_a: assert property (
    !(p_zero_short_o && fs_ref_o) &&
      (sfr_addr_i != MODE_ADDR ||
       (p_zero_short_o == (sfr_rdata_o[2:0] == MD_IZS) &&
        fs_ref_o == (sfr_rdata_o[2:0] == MD_IFS))))
    else $error("short and reference selected together");
endmodule // conv_ctrl_assertions

bind conv_ctrl conv_ctrl_assertions chk (
  .mclk_i, .srst_i, .ce_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
  .sfr_rdata_o, .p_rst_o, .a_rst_o, .p_ext_ref_o, .a_ext_ref_o,
  .p_pair_o, .a_input_o, .p_range_o, .p_zero_short_o, .fs_ref_o,
  .eff_ratio_o
);

// *** tb/sfr_host.sv ***
// Model of the core issuing register reads and writes
`timescale 1ns/100ps
module sfr_host (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= v;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
  endtask

  // Memory bytes arrive the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    @(negedge mclk_i);
    v = rdata_i;
  endtask
endmodule // sfr_host

// *** tb/tb_top.sv ***
// Self-checking bench for converter control
`timescale 1ns/100ps
module tb_top;
  import conv_ctrl_pkg::*;
  localparam int P = 3 * 8 * 13;
  logic        mclk_i;
  logic        srst_i;
  logic        noref;
  logic        p_clamp;
  logic        zs;
  logic        fs;
  logic [23:0] p_smp;
  logic [15:0] a_smp;
  logic [7:0]  addr, wdata, rdata, d, v, eff;
  logic        wr, rd;
  integer      seed = 32'h81a7_dc8d;
  int          n_errors = 0;
  int          check_count = 0;
  logic [7:0]  ra [7] = '{PCFG_ADDR, ACFG_ADDR, MODE_ADDR, DECIM_ADDR,
                          STATUS_ADDR, POFS_H_ADDR, AOFS_H_ADDR};
  logic [7:0]  rv [7] = '{8'h07, 8'h00, 8'h00, 8'h45, 8'h00, 8'h80, 8'h80};

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  sfr_host host (.mclk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                 .wr_o(wr), .rd_o(rd));

  conv_ctrl uut (.mclk_i, .srst_i, .ce_i(1'b1), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .noref_pin_i(noref), .p_sample_i(p_smp), .p_clamp_i(p_clamp),
    .a_sample_i(a_smp), .a_clamp_i(p_clamp), .p_rst_o(), .a_rst_o(),
    .p_ext_ref_o(), .a_ext_ref_o(), .p_pair_o(), .a_input_o(),
    .p_range_o(), .p_zero_short_o(zs), .fs_ref_o(fs), .eff_ratio_o(eff));

  function automatic logic [23:0] pexp(input logic [23:0] s, input logic u);
    return u ? (s ^ 24'h80_0000) : s;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk8(d, e);
  endtask

  task automatic rres(input logic [23:0] e);
    rchk(PRES_L_ADDR, e[7:0]);
    rchk(PRES_M_ADDR, e[15:8]);
    rchk(PRES_H_ADDR, e[23:16]);
  endtask

  // Polls status until the bit sets, bounded
  task automatic wait_rdy(input int b);
    int k;
    k = 0;
    d = 8'h00;
    while (d[b] !== 1'b1 && k < 220) begin
      repeat (64) @(posedge mclk_i);
      host.rd(STATUS_ADDR, d);
      k++;
    end
    chk8({7'h0, d[b]}, 8'h01);
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge mclk_i);
    n_errors++;
    summarize();
  end

  initial begin
    srst_i = 1'b1;
    noref = 1'b0;
    p_clamp = 1'b0;
    p_smp = 24'h80_0000;
    a_smp = 16'h8000;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    repeat (8) begin
      v = 8'($random(seed));
      noref <= 1'($random(seed));
      host.wr(PCFG_ADDR, v);
      rchk(PCFG_ADDR, v & 8'h7f);
      host.wr(ACFG_ADDR, v);
      rchk(ACFG_ADDR, v & 8'h78);
    end
    noref <= 1'b0;
    host.wr(DECIM_ADDR, 8'h0d);
    rchk(DECIM_ADDR, 8'h0d);
    // Single conversion, bipolar, clamped
    host.wr(PCFG_ADDR, 8'h00);
    p_clamp <= 1'b1;
    host.wr(MODE_ADDR, 8'h22);
    repeat (2 * P - 40) @(posedge mclk_i);
    rchk(STATUS_ADDR, 8'h00);
    repeat (60) @(posedge mclk_i);
    rchk(STATUS_ADDR, 8'h88);
    rchk(MODE_ADDR, 8'h20);
    rres(pexp(24'h80_0000, 1'b0));
    p_clamp <= 1'b0;
    // Continuous, unipolar, with hold while ready
    host.wr(STATUS_ADDR, 8'h00);
    host.wr(PCFG_ADDR, 8'h08);
    host.wr(ACFG_ADDR, 8'h00);
    host.wr(MODE_ADDR, 8'h33);
    host.wr(DECIM_ADDR, 8'h20);
    rchk(DECIM_ADDR, 8'h0d);
    host.wr(POFS_L_ADDR, 8'h55);
    rchk(POFS_L_ADDR, 8'h00);
    wait_rdy(7);
    p_smp <= 24'h12_3456;
    repeat (P + 40) @(posedge mclk_i);
    rres(pexp(24'h80_0000, 1'b1));
    wait_rdy(6);
    rchk(ARES_H_ADDR, 8'h80);
    p_clamp <= 1'b1;
    host.wr(STATUS_ADDR, 8'h00);
    repeat (P + 40) @(posedge mclk_i);
    rres(pexp(24'h12_3456, 1'b1));
    rchk(STATUS_ADDR, 8'hcc);
    p_clamp <= 1'b0;
    host.wr(MODE_ADDR, 8'h00);
    host.wr(POFS_L_ADDR, 8'h55);
    rchk(POFS_L_ADDR, 8'h55);
    host.wr(STATUS_ADDR, 8'h00);
    host.wr(MODE_ADDR, 8'h21);
    repeat (2 * P + 40) @(posedge mclk_i);
    rchk(STATUS_ADDR, 8'h00);
    // All four calibrations on the primary
    for (int m = 4; m < 8; m++) begin
      host.wr(MODE_ADDR, 8'h20 | 8'(m));
      @(negedge mclk_i);
      chk8({6'h0, zs, fs}, {6'h0, m == 4, m == 5});
      chk8(eff, 8'hff);
      host.rd(STATUS_ADDR, d);
      chk8(d & 8'he0, 8'h00);
      wait_rdy(7);
      chk8(d & 8'he0, 8'ha0);
      rchk(MODE_ADDR, 8'h20);
      rchk(DECIM_ADDR, 8'h0d);
      rchk(m[0] ? PGN_H_ADDR : POFS_H_ADDR, 8'h92);
    end
    a_smp <= 16'h1234;
    host.wr(ACFG_ADDR, 8'h20);
    host.wr(MODE_ADDR, 8'h14);
    wait_rdy(6);
    chk8(d & 8'h44, 8'h44);
    rchk(AOFS_H_ADDR, 8'h80);
    summarize();
  end
endmodule // tb_top
